// ==== src/eqs_consts.svh ====
// constants for the egress queue scheduler
`ifndef EQS_CONSTS_SVH
`define EQS_CONSTS_SVH

// register word offsets
`define EQS_OFF_CTRL     4'h0
`define EQS_OFF_MAP      4'h1
`define EQS_OFF_W_LO     4'h2
`define EQS_OFF_W_HI     4'h3
`define EQS_OFF_STAT     4'h4
`define EQS_OFF_CMD      4'h5
// field positions in ctrl
`define EQS_CTRL_MODE_LSB 0
`define EQS_CTRL_DSCP_BIT 2
// command bit: restore default map
`define EQS_CMD_RESTORE   0
// reset values, fair queuing slot length and queue count
`define EQS_RST_MODE      2'h0
`define EQS_RST_WEIGHT    7'h01
`define EQS_WFQ_SLOT      8'h10
`define EQS_NQ            8
`define EQS_MAP_RST       24'hfac688

`endif

// ==== src/eqs_pkg.sv ====
// types for the egress queue scheduler
`default_nettype none
package eqs_pkg;
   typedef enum logic [1:0] {
      EQS_SPQ = 2'h0,
      EQS_WRR = 2'h1,
      EQS_WFQ = 2'h3
   } eqs_mode_t;

   typedef enum logic [1:0] {
      EQS_IDLE = 2'h0,
      EQS_GRANT = 2'h1,
      EQS_BUSY = 2'h3
   } eqs_state_t;

   // classified frame from the ingress side
   typedef struct packed {
      logic       valid;
      logic [2:0] tag_prio;
      logic       tag_ok;
      logic [2:0] dscp_prio;
      logic       dscp_ok;
   } eqs_class_t;

   // grant towards the transmit path
   typedef struct packed {
      logic       valid;
      logic [2:0] queue_index;
   } eqs_grant_t;
endpackage : eqs_pkg
`default_nettype wire

// ==== src/eqs_pick.sv ====
// priority picker: first set bit of a request vector searching downward from start, wrapping past 0
`timescale 1ns/1ps
`default_nettype none
module eqs_pick (
   input  wire logic [7:0] req,
   input  wire logic [2:0] start,
   output logic            found,
   output logic [2:0]      idx
);
   // rotating search downward from start, wrapping from 0 to 7
   // later iterations win, so start itself is tried last and takes top precedence
   always_comb begin
      found = 1'b0;
      idx   = 3'h0;
      for (int i = 0; i < 8; i++) begin
         if (req[3'(start + 3'(i + 1))]) begin
            found = 1'b1;
            idx   = 3'(start + 3'(i + 1));
         end
      end
   end
endmodule : eqs_pick
`default_nettype wire

// ==== src/eqs_sched.sv ====
// egress queue scheduler for one switch port
//
// Function
// - frame priority 0..7, 7 highest
// - programmable priority to queue table
// - restore command resets whole table
// - eight queues, queue 7 highest
// - strict mode drains higher queues first
// - round robin weights 1 to 127
// - weighting only matters under backlog
// - larger weight gets more service
// - served queue moves to rotation end
// - fair mode picks queue per slot
// - weights writable only in round robin
// - tag or dscp source precedence selectable
`timescale 1ns/1ps
`include "eqs_consts.svh"
`default_nettype none
module eqs_sched (
   input  wire logic                clk,
   input  wire logic                rstn,
   // avalon-mm slave
   input  wire logic [3:0]          avs_address,
   input  wire logic                avs_read,
   input  wire logic                avs_write,
   input  wire logic [31:0]         avs_writedata,
   output logic [31:0]              avs_readdata,
   output logic                     avs_waitrequest,
   // classification input
   input  wire eqs_pkg::eqs_class_t cls,
   output logic                     cls_queue_valid,
   output logic [2:0]               cls_queue_index,
   // queue occupancy and transmit path
   input  wire logic [7:0]          q_nonempty,
   input  wire logic                tx_ready,
   input  wire logic                tx_done,
   output eqs_pkg::eqs_grant_t      grant
);
   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   eqs_pkg::eqs_mode_t mode_q, mode_act_q;
   logic               dscp_first_q;
   logic [23:0]        map_q;
   logic [6:0]         wt_q   [8];
   logic [6:0]         wt_act [8];
   logic               rd_done_q;
   logic [31:0]        rdata_d;
   logic               wr_hit;

   // weight clamp: 0 is illegal, stored as 1
   function automatic logic [6:0] clamp_w(input logic [7:0] b);
      return (b[6:0] == 7'h00) ? `EQS_RST_WEIGHT : b[6:0];
   endfunction : clamp_w

   function automatic logic [2:0] map_of(input logic [23:0] m, input logic [2:0] p);
      return m[3*p +: 3];
   endfunction : map_of

   // writes finish in one cycle, reads wait one cycle for registered data
   assign avs_waitrequest = avs_read & ~rd_done_q;
   assign wr_hit          = avs_write;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_done_q <= 1'b0;
      end else begin
         rd_done_q <= avs_read & ~rd_done_q;
      end
   end

   // ctrl register: mode and precedence
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mode_q       <= eqs_pkg::eqs_mode_t'(`EQS_RST_MODE);
         dscp_first_q <= 1'b0;
      end else if (wr_hit && avs_address == `EQS_OFF_CTRL) begin
         if (avs_writedata[`EQS_CTRL_MODE_LSB +: 2] != 2'h2)
            mode_q <= eqs_pkg::eqs_mode_t'(avs_writedata[`EQS_CTRL_MODE_LSB +: 2]);
         dscp_first_q <= avs_writedata[`EQS_CTRL_DSCP_BIT];
      end
   end

   // map table; restore wins over a same cycle table write by design
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         map_q <= `EQS_MAP_RST;
      end else if (wr_hit && avs_address == `EQS_OFF_CMD
                   && avs_writedata[`EQS_CMD_RESTORE]) begin
         map_q <= `EQS_MAP_RST;
      end else if (wr_hit && avs_address == `EQS_OFF_MAP) begin
         map_q <= avs_writedata[23:0];
      end
   end

   // weights accepted only in round robin mode
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < `EQS_NQ; i++) wt_q[i] <= `EQS_RST_WEIGHT;
      end else if (wr_hit && mode_q == eqs_pkg::EQS_WRR) begin
         for (int i = 0; i < 4; i++) begin
            if (avs_address == `EQS_OFF_W_LO) wt_q[i] <= clamp_w(avs_writedata[8*i +: 8]);
            if (avs_address == `EQS_OFF_W_HI) wt_q[i+4] <= clamp_w(avs_writedata[8*i +: 8]);
         end
      end
   end

   // read mux, registered so read data comes from flip-flops
   always_comb begin
      rdata_d = 32'h0;
      case (avs_address)
         `EQS_OFF_CTRL: rdata_d = {29'h0, dscp_first_q, mode_q};
         `EQS_OFF_MAP:  rdata_d = {8'h0, map_q};
         `EQS_OFF_W_LO: rdata_d = {1'b0, wt_q[3], 1'b0, wt_q[2], 1'b0, wt_q[1], 1'b0, wt_q[0]};
         `EQS_OFF_W_HI: rdata_d = {1'b0, wt_q[7], 1'b0, wt_q[6], 1'b0, wt_q[5], 1'b0, wt_q[4]};
         `EQS_OFF_STAT: rdata_d = {18'h0, grant.valid, grant.queue_index, mode_act_q, q_nonempty};
         default:       rdata_d = 32'h0;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) avs_readdata <= 32'h0;
      else if (avs_read && !rd_done_q) avs_readdata <= rdata_d;
   end

   // ------------------------------------------------------------
   // classification to queue
   // ------------------------------------------------------------
   logic [2:0] prio_sel;
   // precedence between tag and dscp priority
   always_comb begin
      if (cls.dscp_ok && (dscp_first_q || !cls.tag_ok)) prio_sel = cls.dscp_prio;
      else prio_sel = cls.tag_prio;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cls_queue_valid <= 1'b0;
         cls_queue_index <= 3'h0;
      end else begin
         cls_queue_valid <= cls.valid & (cls.tag_ok | cls.dscp_ok);
         cls_queue_index <= map_of(map_q, prio_sel);
      end
   end

   // ------------------------------------------------------------
   // scheduler
   // ------------------------------------------------------------
   eqs_pkg::eqs_state_t st_q;
   logic [2:0]  rr_ptr_q;
   logic [6:0]  credit_q;
   logic [7:0]  slot_q;
   logic [2:0]  wfq_ptr_q;
   logic [7:0]  vt_q [8];
   logic        rr_found, sp_found;
   logic [2:0]  rr_idx, sp_idx;
   logic [2:0]  pick;
   logic        pick_ok;
   logic        boundary;

   assign boundary = (st_q == eqs_pkg::EQS_IDLE);

   // latch mode and weights only between packets
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mode_act_q <= eqs_pkg::eqs_mode_t'(`EQS_RST_MODE);
         for (int i = 0; i < `EQS_NQ; i++) wt_act[i] <= `EQS_RST_WEIGHT;
      end else if (boundary) begin
         mode_act_q <= mode_q;
         for (int i = 0; i < `EQS_NQ; i++) wt_act[i] <= wt_q[i];
      end
   end

   eqs_pick u_sp (
      .req   (q_nonempty),
      .start (3'h7),
      .found (sp_found),
      .idx   (sp_idx)
   );

   // rotation continues below the queue last served
   // starting one below the pointer keeps a spent queue from grabbing the turn again
   eqs_pick u_rr (
      .req   (q_nonempty),
      .start (3'(rr_ptr_q - 3'h1)),
      .found (rr_found),
      .idx   (rr_idx)
   );

   // choose the next queue for the active mode
   always_comb begin
      pick    = sp_idx;
      pick_ok = sp_found;
      case (mode_act_q)
         eqs_pkg::EQS_SPQ: pick = sp_idx;
         // with one queue busy it is simply served
         eqs_pkg::EQS_WRR: pick = (credit_q != 7'h0 && q_nonempty[rr_ptr_q]) ? rr_ptr_q : rr_idx;
         eqs_pkg::EQS_WFQ: begin
            pick = sp_idx;
            // least virtual time wins this slot
            for (int i = 0; i < `EQS_NQ; i++)
               if (q_nonempty[i] && vt_q[i] < vt_q[pick]) pick = 3'(i);
         end
         default: pick = sp_idx;
      endcase
   end

   // grant state machine
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q  <= eqs_pkg::EQS_IDLE;
         grant <= '0;
      end else begin
         case (st_q)
            // grant only a non-empty queue when tx is ready
            eqs_pkg::EQS_IDLE: if (pick_ok && tx_ready) begin
               grant <= '{valid: 1'b1, queue_index: pick};
               st_q  <= eqs_pkg::EQS_GRANT;
            end
            eqs_pkg::EQS_GRANT: begin
               grant.valid <= 1'b0;
               st_q        <= tx_done ? eqs_pkg::EQS_IDLE : eqs_pkg::EQS_BUSY;
            end
            eqs_pkg::EQS_BUSY: if (tx_done) st_q <= eqs_pkg::EQS_IDLE;
            default: st_q <= eqs_pkg::EQS_IDLE;
         endcase
      end
   end

   // round robin credit: weight packets per visit
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rr_ptr_q <= 3'h7;
         credit_q <= 7'h0;
      end else if (boundary && pick_ok && tx_ready && mode_act_q == eqs_pkg::EQS_WRR) begin
         if (pick == rr_ptr_q && credit_q != 7'h0) begin
            credit_q <= 7'(credit_q - 7'h1);
         end else begin
            rr_ptr_q <= pick;
            credit_q <= 7'(wt_act[pick] - 7'h1);
         end
      end
   end

   // fair queuing virtual time: step inversely to weight, slot timer
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < `EQS_NQ; i++) vt_q[i] <= 8'h0;
         slot_q    <= 8'h0;
         wfq_ptr_q <= 3'h0;
      end else begin
         slot_q <= (slot_q == `EQS_WFQ_SLOT) ? 8'h0 : 8'(slot_q + 8'h1);
         if (boundary && pick_ok && tx_ready && mode_act_q == eqs_pkg::EQS_WFQ) begin
            wfq_ptr_q <= pick;
            vt_q[pick] <= 8'(vt_q[pick] + 8'(8'h80 / {1'b0, wt_act[pick]}));
         end else if (slot_q == `EQS_WFQ_SLOT) begin
            // age all clocks so that none wraps
            for (int i = 0; i < `EQS_NQ; i++)
               vt_q[i] <= (vt_q[i] > 8'h0) ? 8'(vt_q[i] - 8'h1) : 8'h0;
         end
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_grant_nonempty: assert property (@(posedge clk) disable iff (!rstn)
      $rose(grant.valid)
      |-> (($past(q_nonempty) >> grant.queue_index) & 8'h01) == 8'h01 && $past(tx_ready))
      else $error("grant to empty queue or tx not ready");
   a_grant_pulse: assert property (@(posedge clk) disable iff (!rstn)
      grant.valid |=> !grant.valid)
      else $error("grant longer than one cycle");
   a_sp_highest: assert property (@(posedge clk) disable iff (!rstn)
      $rose(grant.valid) && $past(mode_act_q) == eqs_pkg::EQS_SPQ
      |-> ($past(q_nonempty) >> grant.queue_index) <= 8'h1)
      else $error("strict mode skipped higher queue");
   a_wt_locked: assert property (@(posedge clk) disable iff (!rstn)
      mode_q != eqs_pkg::EQS_WRR |=> $stable(wt_q[0]) && $stable(wt_q[7]))
      else $error("weight changed outside round robin");
   a_restore_map: assert property (@(posedge clk) disable iff (!rstn)
      wr_hit && avs_address == `EQS_OFF_CMD && avs_writedata[`EQS_CMD_RESTORE]
      |=> map_q == `EQS_MAP_RST)
      else $error("restore did not reset map");
   a_mode_boundary: assert property (@(posedge clk) disable iff (!rstn)
      st_q != eqs_pkg::EQS_IDLE |=> $stable(mode_act_q))
      else $error("mode changed mid packet");
   a_map_lookup: assert property (@(posedge clk) disable iff (!rstn)
      cls.valid && cls.tag_ok && !cls.dscp_ok
      |=> cls_queue_index == map_of($past(map_q), $past(cls.tag_prio)))
      else $error("queue index not from table");
   a_weight_min: assert property (@(posedge clk) disable iff (!rstn)
      wt_q[3] != 7'h00)
      else $error("weight out of range");
   a_busy_hold: assert property (@(posedge clk) disable iff (!rstn)
      st_q == eqs_pkg::EQS_BUSY && !tx_done |=> st_q == eqs_pkg::EQS_BUSY)
      else $error("left busy without done");

   c_wrr_grant: cover property (@(posedge clk) disable iff (!rstn)
      $rose(grant.valid) && mode_act_q == eqs_pkg::EQS_WRR);
   c_wfq_grant: cover property (@(posedge clk) disable iff (!rstn)
      $rose(grant.valid) && mode_act_q == eqs_pkg::EQS_WFQ);
   c_restore: cover property (@(posedge clk) disable iff (!rstn)
      wr_hit && avs_address == `EQS_OFF_CMD);
endmodule : eqs_sched
`default_nettype wire

// ==== sim/eqs_txm.sv ====
// transmit path and queue occupancy model facing the egress scheduler
`timescale 1ns/1ps
`default_nettype none
module eqs_txm (
   input  wire logic                clk,
   input  wire logic                rstn,
   input  wire eqs_pkg::eqs_grant_t grant,
   input  wire logic [7:0]          add,
   input  wire logic [3:0]          plen,
   output logic [7:0]               q_nonempty,
   output logic                     tx_ready,
   output logic                     tx_done
);
   int         cnt_q [8];
   logic [3:0] left_q;

   assign tx_ready = (left_q == 4'h0);

   // occupancy and packet timer; done comes plen+1 cycles after the grant cycle, and a plen of 0 never raises it
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         left_q  <= 4'h0;
         tx_done <= 1'b0;
         for (int i = 0; i < 8; i++) cnt_q[i] <= 0;
      end else begin
         tx_done <= (left_q == 4'h1);
         if (grant.valid) left_q <= plen;
         else if (left_q != 4'h0) left_q <= left_q - 4'h1;
         for (int i = 0; i < 8; i++) begin
            cnt_q[i] <= cnt_q[i] + int'(add[i]) - int'(grant.valid && grant.queue_index == i);
         end
      end
   end

   // a queue shows non-empty while any packet is counted in it
   always_comb begin
      for (int i = 0; i < 8; i++) q_nonempty[i] = (cnt_q[i] != 0);
   end
endmodule : eqs_txm
`default_nettype wire

// ==== sim/test_eqs_sched.sv ====
// self-checking bench for the egress queue scheduler
`timescale 1ns/1ps
`include "eqs_consts.svh"
`default_nettype none
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin err_count++; \
   $display("wrong value %s expected %h seen %h", nm, e, s); end end
module test_eqs_sched;
   logic                clk, rstn, avs_read, avs_write, avs_waitrequest;
   logic                cls_queue_valid, tx_ready, tx_done;
   logic [3:0]          avs_address, plen;
   logic [31:0]         avs_writedata, avs_readdata, d, mapv;
   logic [2:0]          cls_queue_index;
   logic [7:0]          q_nonempty, add;
   eqs_pkg::eqs_class_t cls;
   eqs_pkg::eqs_grant_t grant;
   logic [2:0]          glog [0:255];
   int                  gn, b, c, cyc, err_count, cmp_count;

   eqs_sched dut (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .cls(cls), .cls_queue_valid(cls_queue_valid),
      .cls_queue_index(cls_queue_index), .q_nonempty(q_nonempty), .tx_ready(tx_ready),
      .tx_done(tx_done), .grant(grant));
   eqs_txm txm (.clk(clk), .rstn(rstn), .grant(grant), .add(add), .plen(plen),
      .q_nonempty(q_nonempty), .tx_ready(tx_ready), .tx_done(tx_done));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // grant log, sampled at the edge where the pulse stands
   always @(posedge clk) begin
      cyc++;
      if (grant.valid === 1'b1) begin
         glog[gn[7:0]] = grant.queue_index;
         gn++;
      end
      if (cyc > 30000) begin
         err_count++;
         complete_run();
      end
   end

   // one bus cycle; request held until waitrequest is seen low at a rising edge
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk);
      avs_write     <= wr;
      avs_read      <= !wr;
      avs_address   <= a;
      avs_writedata <= wd;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      // read data taken at the same edge that ends the wait
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask : bus

   task cls_chk(input logic [2:0] tp, input logic tok, input logic [2:0] dp, input logic dok,
                input logic [2:0] eq);
      @(posedge clk) cls <= '{1'b1, tp, tok, dp, dok};
      @(posedge clk) cls <= '0;
      @(negedge clk);
      `CHK("cls valid", 1'b1, cls_queue_valid)
      `CHK("cls queue", eq, cls_queue_index)
   endtask : cls_chk

   task fill(input logic [7:0] m, input int n);
      repeat (n) @(posedge clk) add <= m;
      @(posedge clk) add <= 8'h00;
   endtask : fill

   // bounded wait for n grants counted from b, then a quiet spell for spare grants
   task gwait(input int n);
      int k;
      k = 0;
      while (gn < b + n && k < 3000) begin
         @(negedge clk);
         k++;
      end
      repeat (30) @(negedge clk);
      `CHK("grant count", b + n, gn)
   endtask : gwait

   task complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : complete_run

   initial begin
      rstn = 1'b0; avs_address = 4'h0; avs_read = 1'b0; avs_write = 1'b0;
      avs_writedata = 32'h0; cls = '0; add = 8'h00; plen = 4'h3;
      gn = 0; cyc = 0; err_count = 0; cmp_count = 0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      bus(1'b0, `EQS_OFF_MAP, 32'h0, d);
      `CHK("map reset", `EQS_MAP_RST, d[23:0])
      bus(1'b0, `EQS_OFF_CTRL, 32'h0, d);
      `CHK("ctrl reset", 32'h0, d)
      bus(1'b1, 4'h9, 32'hffffffff, d);
      bus(1'b0, 4'h9, 32'h0, d);
      `CHK("unmapped", 32'h0, d)
      // weights refused outside round robin
      bus(1'b1, `EQS_OFF_W_LO, 32'h05050505, d);
      bus(1'b0, `EQS_OFF_W_LO, 32'h0, d);
      `CHK("weights spq", 32'h01010101, d)
      // reversed table, every priority and queue once
      mapv = 32'h0;
      for (int p = 0; p < 8; p++) mapv[3*p +: 3] = 3'(7 - p);
      bus(1'b1, `EQS_OFF_MAP, mapv, d);
      for (int p = 0; p < 8; p++) cls_chk(3'(p), 1'b1, 3'h0, 1'b0, 3'(7 - p));
      cls_chk(3'h2, 1'b0, 3'h6, 1'b1, 3'h1);
      bus(1'b1, `EQS_OFF_CTRL, 32'h4, d);
      cls_chk(3'h0, 1'b1, 3'h7, 1'b1, 3'h0);
      bus(1'b1, `EQS_OFF_CTRL, 32'h0, d);
      cls_chk(3'h0, 1'b1, 3'h7, 1'b1, 3'h7);
      bus(1'b1, `EQS_OFF_CMD, 32'h1, d);
      bus(1'b0, `EQS_OFF_MAP, 32'h0, d);
      `CHK("map restore", `EQS_MAP_RST, d[23:0])
      // strict: higher queue drains first
      b = gn;
      fill(8'h24, 2);
      gwait(4);
      for (int i = 0; i < 4; i++) `CHK("spq order", (i < 2) ? 3'h5 : 3'h2, glog[b + i])
      // mode change during a long packet waits for the boundary
      plen <= 4'hc;
      b = gn;
      fill(8'h08, 1);
      while (gn == b) @(negedge clk);
      bus(1'b1, `EQS_OFF_CTRL, 32'h1, d);
      bus(1'b0, `EQS_OFF_STAT, 32'h0, d);
      `CHK("mode busy", 2'h0, d[9:8])
      gwait(1);
      bus(1'b0, `EQS_OFF_STAT, 32'h0, d);
      `CHK("stat idle", 5'h0d, d[12:8])
      plen <= 4'h3;
      // round robin weights, zero stored as one, top value kept
      bus(1'b1, `EQS_OFF_W_LO, 32'h00027f05, d);
      bus(1'b1, `EQS_OFF_W_HI, 32'h01030101, d);
      bus(1'b0, `EQS_OFF_W_LO, 32'h0, d);
      `CHK("weights lo", 32'h01027f05, d)
      b = gn;
      fill(8'hc0, 4);
      gwait(8);
      c = 0;
      for (int i = 0; i < 4; i++) c += int'(glog[b + i] == 3'h6);
      `CHK("wrr share", 3, c)
      `CHK("wrr rotate", 1'b1, glog[b] != glog[b + 3])
      b = gn;
      fill(8'h01, 3);
      gwait(3);
      for (int i = 0; i < 3; i++) `CHK("wrr light", 3'h0, glog[b + i])
      // fair queuing keeps weights and refuses new ones
      bus(1'b1, `EQS_OFF_CTRL, 32'h3, d);
      bus(1'b1, `EQS_OFF_W_HI, 32'h7f7f7f7f, d);
      bus(1'b0, `EQS_OFF_W_HI, 32'h0, d);
      `CHK("weights wfq", 32'h01030101, d)
      b = gn;
      fill(8'h03, 3);
      gwait(6);
      c = 0;
      for (int i = 0; i < 6; i++) c += int'(glog[b + i] == 3'h1);
      `CHK("wfq both served", 3, c)
      bus(1'b0, `EQS_OFF_STAT, 32'h0, d);
      `CHK("wfq active", 2'h3, d[9:8])
      `CHK("idle queues", 8'h00, d[7:0])
      complete_run();
   end
endmodule : test_eqs_sched
`default_nettype wire
